// ### rtl/rtc_second_minute_counters.sv
`timescale 1ns/1ps
`include "rtc_sm_defines.svh"

// Functional notes
// - Seconds hold BCD 00 to 59
// - Free-run mode: seconds is 8-bit binary counter
// - Bit 7 reads update in progress flag, except seconds in free-run mode
// - Seconds tens digit counts 0 to 5
// - Seconds ones digit counts 0-9 per tick
// - Ones wrap carries one into tens digit
// - Minutes advance on seconds carry outside free-run mode
// - Minutes hold BCD 00 to 59
// - Minutes tens digit counts 0 to 5
// - Minutes ones digit counts 0-9 per carry
// - Minutes emit hourly carry to hour stage
module rtc_second_minute_counters
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire rtc_sm_pkg::adr_t wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire rtc_sm_pkg::word_t wb_dat_i,
  output logic wb_ack_o,
  output rtc_sm_pkg::word_t wb_dat_o,
  // Time base and hour stage
  input wire logic sec_tick_i,
  input wire logic hour_busy_i,
  output logic hour_carry_o,
  output logic update_in_progress_o
);
  import rtc_sm_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  upd_state_t state;
  upd_state_t next_state;
  logic run_en;
  logic next_run_en;
  logic free_run;
  logic next_free_run;
  logic clr_pulse;
  logic next_clr_pulse;
  logic tick_pend;
  logic next_tick_pend;
  logic hour_carry;
  logic next_hour_carry;
  logic busy_q;
  logic next_busy_q;
  logic wr_stb;
  logic wr_sec;
  logic wr_min;
  logic wr_ctrl;
  logic sec_inc;
  logic min_inc;
  logic sec_carry;
  logic min_carry;
  logic update_in_progress;
  logic tick_ok;
  logic min_step;
  logic [2:0] sec_tens;
  logic [3:0] sec_ones;
  logic [2:0] min_tens;
  logic [3:0] min_ones;
  cnt_t sec_val;
  cnt_t min_val;
  cnt_t wr_val;
  word_t rd_data;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  rtc_wb_slave u_bus
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .rd_data_i(rd_data),
    .wr_stb_o(wr_stb)
  );

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Lane 0 carries every field; other lanes are acked and dropped
  // Free-run seconds is a read-only counter, so its writes are dropped
  assign wr_sec = wr_stb & (wb_adr_i == `RTC_SEC_OFS) & ~free_run;
  assign wr_min = wr_stb & (wb_adr_i == `RTC_MIN_OFS);
  assign wr_ctrl = wr_stb & (wb_adr_i == `RTC_CTRL_OFS);

  assign wr_val = {1'b0, wb_dat_i[`RTC_TENS_MSB:`RTC_ONES_LSB]};

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_comb
  begin
    next_run_en = run_en;
    next_free_run = free_run;
    next_clr_pulse = 1'b0;
    if (wr_ctrl)
    begin
      next_run_en = wb_dat_i[`RTC_CTRL_RUN];
      next_free_run = wb_dat_i[`RTC_CTRL_FREE];
      // Clear is self-clearing, so it reads back as zero
      next_clr_pulse = wb_dat_i[`RTC_CTRL_CLR];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      run_en <= `RTC_RUN_RST;
      free_run <= `RTC_FREE_RST;
      clr_pulse <= 1'b0;
    end
    else
    begin
      run_en <= next_run_en;
      free_run <= next_free_run;
      clr_pulse <= next_clr_pulse;
    end
  end

  // ----------------------------------------------------------------
  // Tick qualifier
  // ----------------------------------------------------------------
  // A stopped clock drops its ticks here instead of queueing them
  assign tick_ok = sec_tick_i & run_en;

  // ----------------------------------------------------------------
  // Minute step
  // ----------------------------------------------------------------
  // minutes follow seconds carry
  // Free-running seconds are a plain count, so they never move minutes
  assign min_step = sec_carry & ~free_run;

  // ----------------------------------------------------------------
  // Update sequencer
  // ----------------------------------------------------------------
  // A tick that lands while an update runs is held in one pending flag until idle; a clear drops it
  always_comb
  begin
    next_state = state;
    next_tick_pend = tick_pend;
    next_hour_carry = 1'b0;
    sec_inc = 1'b0;
    min_inc = 1'b0;
    if (tick_ok)
    begin
      next_tick_pend = 1'b1;
    end
    case (state)
      ST_IDLE:
      begin
        if (tick_pend && run_en)
        begin
          next_state = ST_SEC;
          // Set wins: a new tick this cycle keeps the pending flag
          next_tick_pend = tick_ok;
        end
      end
      ST_SEC:
      begin
        sec_inc = 1'b1;
        next_state = ST_MIN;
      end
      ST_MIN:
      begin
        min_inc = min_step;
        next_state = ST_HOUR;
      end
      ST_HOUR:
      begin
        next_hour_carry = min_carry;
        next_state = ST_HOLD;
      end
      ST_HOLD:
      begin
        // Flag stays up while the hour stage takes its carry
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    if (clr_pulse)
    begin
      next_state = ST_IDLE;
      // Clear drops an old tick; a new one still wins
      next_tick_pend = tick_ok;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      tick_pend <= 1'b0;
      hour_carry <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tick_pend <= next_tick_pend;
      hour_carry <= next_hour_carry;
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  // Both stages use one counter module; only seconds may run binary
  // seconds BCD 00-59
  rtc_sixty_counter u_sec
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clear_i(clr_pulse),
    .load_i(wr_sec),
    .load_val_i(wr_val),
    .inc_i(sec_inc),
    .bin_mode_i(free_run),
    .value_o(sec_val),
    .carry_o(sec_carry)
  );

  rtc_sixty_counter u_min
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clear_i(clr_pulse),
    .load_i(wr_min),
    .load_val_i(wr_val),
    .inc_i(min_inc),
    .bin_mode_i(1'b0),
    .value_o(min_val),
    .carry_o(min_carry)
  );

  // ----------------------------------------------------------------
  // Update flag
  // ----------------------------------------------------------------
  // busy during any update
  // hour_busy_i keeps it up while the hour stage works
  always_comb
  begin
    next_busy_q = (next_state != ST_IDLE) | hour_busy_i;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= next_busy_q;
    end
  end

  // Registered copy is taken from next_state, so it matches the raw state term in time
  assign update_in_progress = busy_q | (state != ST_IDLE);

  // ----------------------------------------------------------------
  // Digit fields
  // ----------------------------------------------------------------
  // Named digits keep the read mux short
  // seconds tens 0-5
  assign sec_tens = sec_val[`RTC_TENS_MSB:`RTC_TENS_LSB];
  assign sec_ones = sec_val[`RTC_ONES_MSB:`RTC_ONES_LSB];
  assign min_tens = min_val[`RTC_TENS_MSB:`RTC_TENS_LSB];
  assign min_ones = min_val[`RTC_ONES_MSB:`RTC_ONES_LSB];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // flag shown beside the count
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `RTC_SEC_OFS:
      begin
        if (free_run)
        begin
          rd_data[7:0] = sec_val;
        end
        else
        begin
          rd_data[7:0] = {update_in_progress, sec_tens, sec_ones};
        end
      end
      `RTC_MIN_OFS:
      begin
        rd_data[7:0] = {update_in_progress, min_tens, min_ones};
      end
      `RTC_CTRL_OFS:
      begin
        rd_data[`RTC_CTRL_RUN] = run_en;
        rd_data[`RTC_CTRL_FREE] = free_run;
      end
      `RTC_STAT_OFS:
      begin
        rd_data[`RTC_STAT_BUSY] = update_in_progress;
        rd_data[`RTC_STAT_PEND] = tick_pend;
      end
      default:
      begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  assign hour_carry_o = hour_carry;
  assign update_in_progress_o = busy_q;

endmodule : rtc_second_minute_counters

// ### rtl/rtc_sixty_counter.sv
`timescale 1ns/1ps
`include "rtc_sm_defines.svh"

module rtc_sixty_counter
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clear_i,
  input wire logic load_i,
  input wire rtc_sm_pkg::cnt_t load_val_i,
  input wire logic inc_i,
  input wire logic bin_mode_i,
  // State
  output rtc_sm_pkg::cnt_t value_o,
  output logic carry_o
);
  import rtc_sm_pkg::*;

  cnt_t value;
  cnt_t next_value;
  logic carry;
  logic next_carry;
  logic [8:0] inc_res;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    inc_res = cnt_inc(value, bin_mode_i);
    next_value = value;
    next_carry = 1'b0;
    if (clear_i)
    begin
      next_value = `RTC_CNT_RST;
    end
    else if (load_i)
    begin
      // Software write wins over a tick in the same cycle
      next_value = load_val_i;
    end
    else if (inc_i)
    begin
      next_value = inc_res[7:0];
      next_carry = inc_res[8];
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      value <= `RTC_CNT_RST;
      carry <= 1'b0;
    end
    else
    begin
      value <= next_value;
      carry <= next_carry;
    end
  end

  assign value_o = value;
  assign carry_o = carry;

endmodule : rtc_sixty_counter

// ### rtl/rtc_sm_defines.svh
`ifndef RTC_SM_DEFINES_SVH
`define RTC_SM_DEFINES_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define RTC_ADR_W 8
`define RTC_SEC_OFS 8'h00
`define RTC_MIN_OFS 8'h04
`define RTC_CTRL_OFS 8'h08
`define RTC_STAT_OFS 8'h0C

// ----------------------------------------------------------------
// Field positions and limits
// ----------------------------------------------------------------
`define RTC_BUSY_BIT 7
`define RTC_TENS_MSB 6
`define RTC_TENS_LSB 4
`define RTC_ONES_MSB 3
`define RTC_ONES_LSB 0
`define RTC_TENS_MAX 3'h5
`define RTC_ONES_MAX 4'h9
`define RTC_BIN_MAX 8'hFF
`define RTC_CTRL_RUN 0
`define RTC_CTRL_FREE 1
`define RTC_CTRL_CLR 2
`define RTC_STAT_BUSY 0
`define RTC_STAT_PEND 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RTC_CNT_RST 8'h00
`define RTC_RUN_RST 1'h1
`define RTC_FREE_RST 1'h0

`endif

// ### rtl/rtc_sm_pkg.sv
`include "rtc_sm_defines.svh"

package rtc_sm_pkg;

  typedef logic [7:0] cnt_t;
  typedef logic [31:0] word_t;
  typedef logic [`RTC_ADR_W-1:0] adr_t;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_SEC = 5'h02,
    ST_MIN = 5'h04,
    ST_HOUR = 5'h08,
    ST_HOLD = 5'h10
  } upd_state_t;

  // Returns {carry, next value}; a ones digit past its limit also wraps, a tens digit only at ones rollover
  function automatic logic [8:0] cnt_inc(input cnt_t v, input logic bin);
    logic [2:0] tens;
    logic [3:0] ones;
    tens = v[`RTC_TENS_MSB:`RTC_TENS_LSB];
    ones = v[`RTC_ONES_MSB:`RTC_ONES_LSB];
    if (bin)
    begin
      cnt_inc = {(v == `RTC_BIN_MAX), 8'(v + 8'h01)};
    end
    else if (ones >= `RTC_ONES_MAX && tens >= `RTC_TENS_MAX)
    begin
      cnt_inc = {1'b1, `RTC_CNT_RST};
    end
    else if (ones >= `RTC_ONES_MAX)
    begin
      cnt_inc = {1'b0, 1'b0, 3'(tens + 3'h1), 4'h0};
    end
    else
    begin
      cnt_inc = {1'b0, 1'b0, tens, 4'(ones + 4'h1)};
    end
  endfunction : cnt_inc

endpackage : rtc_sm_pkg

// ### rtl/rtc_wb_slave.sv
`timescale 1ns/1ps
`include "rtc_sm_defines.svh"

module rtc_wb_slave
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output rtc_sm_pkg::word_t wb_dat_o,
  // Register side
  input wire rtc_sm_pkg::word_t rd_data_i,
  output logic wr_stb_o
);
  import rtc_sm_pkg::*;

  logic ack;
  logic next_ack;
  word_t dat;
  word_t next_dat;
  logic req;

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  // A new request is taken only while ack is low, so ack is one cycle
  assign req = wb_cyc_i & wb_stb_i & ~ack;

  always_comb
  begin
    next_ack = req;
    next_dat = req ? rd_data_i : dat;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
      dat <= 32'h0000_0000;
    end
    else
    begin
      ack <= next_ack;
      dat <= next_dat;
    end
  end

  // Write lands on the edge where the master sees ack; lane 0 only
  assign wr_stb_o = ack & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
  assign wb_ack_o = ack;
  assign wb_dat_o = dat;

endmodule : rtc_wb_slave

// ### testbench/rtc_sm_properties.sv
`timescale 1ns/1ps

module rtc_sm_checker
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire rtc_sm_pkg::adr_t wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire rtc_sm_pkg::word_t wb_dat_i,
  input wire logic wb_ack_o,
  input wire rtc_sm_pkg::word_t wb_dat_o,
  // Time base and hour stage
  input wire logic sec_tick_i,
  input wire logic hour_busy_i,
  input wire logic hour_carry_o,
  input wire logic update_in_progress_o
);
  import rtc_sm_pkg::*;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  AST_ACK_LATENCY: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");

  // ----------------------------------------------------------------
  // Counting and update flag
  // ----------------------------------------------------------------
  AST_MIN_RANGE: assert property
    (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |-> wb_dat_o[6:4] <= 3'h5
     && wb_dat_o[3:0] <= 4'h9 && wb_dat_o[31:8] == 24'h0)
    else $error("minutes read out of range");
  AST_UPD_CAUSE: assert property
    ($rose(update_in_progress_o) |-> $past(sec_tick_i, 1)
     || $past(sec_tick_i, 2) || $past(sec_tick_i, 3)
     || $past(hour_busy_i, 1) || $past(hour_busy_i, 2))
    else $error("update flag rose without cause");
  AST_UPD_BOUNDED: assert property
    ($rose(update_in_progress_o) && !hour_busy_i
     |-> ##[1:8] !update_in_progress_o)
    else $error("update flag stuck high");
  AST_CARRY_PULSE: assert property (hour_carry_o |=> !hour_carry_o)
    else $error("hour carry longer than one cycle");
  AST_CARRY_TICK: assert property
    (hour_carry_o |-> $past(sec_tick_i, 3) || $past(sec_tick_i, 4)
     || $past(sec_tick_i, 5))
    else $error("hour carry without tick");
  AST_CARRY_IN_UPD: assert property
    (hour_carry_o |-> update_in_progress_o)
    else $error("hour carry outside update");
endmodule : rtc_sm_checker

bind rtc_second_minute_counters rtc_sm_checker u_chk
(
  .core_clk_i(core_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .sec_tick_i(sec_tick_i),
  .hour_busy_i(hour_busy_i), .hour_carry_o(hour_carry_o),
  .update_in_progress_o(update_in_progress_o)
);

// ### testbench/testbench.sv
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module testbench;
  import rtc_sm_pkg::*;

  logic core_clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic sec_tick_i, hour_busy_i, hour_carry_o, update_in_progress_o;
  logic [3:0] wb_sel_i;
  adr_t wb_adr_i;
  word_t wb_dat_i, wb_dat_o, rd_val;
  int err_count = 0;
  int check_count = 0;
  int carry_cnt = 0;

  rtc_second_minute_counters dut
  (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .sec_tick_i(sec_tick_i),
    .hour_busy_i(hour_busy_i), .hour_carry_o(hour_carry_o),
    .update_in_progress_o(update_in_progress_o)
  );

  // ----------------------------------------------------------------
  // Bus and tick helpers
  // ----------------------------------------------------------------
  task wb_cycle(input logic we, input adr_t a, input word_t d);
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    // Wait for ack; only the watchdog ends a hung wait
    do @(posedge core_clk_i); while (wb_ack_o !== 1'b1);
    rd_val = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_cycle

  // Ten cycles cover the whole five-step update walk
  task tick;
    @(posedge core_clk_i);
    sec_tick_i <= 1'b1;
    @(posedge core_clk_i);
    sec_tick_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
  endtask : tick

  always @(posedge core_clk_i)
    if (hour_carry_o === 1'b1)
      carry_cnt <= carry_cnt + 1;

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    wb_cycle(1'b0, 8'h00, 32'h0);
    `CHK(rd_val, 32'h00)
    wb_cycle(1'b0, 8'h04, 32'h0);
    `CHK(rd_val, 32'h00)
    wb_cycle(1'b1, 8'h10, 32'h55);
    wb_cycle(1'b0, 8'h10, 32'h0);
    `CHK(rd_val, 32'h00)
  endtask : t_reset

  task t_bcd;
    wb_cycle(1'b1, 8'h00, 32'hD8);
    wb_cycle(1'b0, 8'h00, 32'h0);
    `CHK(rd_val, 32'h58)
    tick();
    wb_cycle(1'b0, 8'h00, 32'h0);
    `CHK(rd_val, 32'h59)
    wb_cycle(1'b1, 8'h04, 32'hD9);
    wb_cycle(1'b0, 8'h04, 32'h0);
    `CHK(rd_val, 32'h59)
    tick();
    wb_cycle(1'b0, 8'h00, 32'h0);
    `CHK(rd_val, 32'h00)
    wb_cycle(1'b0, 8'h04, 32'h0);
    `CHK(rd_val, 32'h00)
    `CHK(carry_cnt, 1)
    wb_cycle(1'b1, 8'h00, 32'h09);
    tick();
    wb_cycle(1'b0, 8'h00, 32'h0);
    `CHK(rd_val, 32'h10)
    wb_cycle(1'b1, 8'h00, 32'h59);
    wb_cycle(1'b1, 8'h04, 32'h09);
    tick();
    wb_cycle(1'b0, 8'h04, 32'h0);
    `CHK(rd_val, 32'h10)
    `CHK(carry_cnt, 1)
  endtask : t_bcd

  task t_free;
    wb_cycle(1'b1, 8'h00, 32'h59);
    wb_cycle(1'b1, 8'h08, 32'h03);
    tick();
    wb_cycle(1'b0, 8'h00, 32'h0);
    `CHK(rd_val, 32'h5A)
    wb_cycle(1'b1, 8'h00, 32'h11);
    wb_cycle(1'b0, 8'h00, 32'h0);
    `CHK(rd_val, 32'h5A)
    wb_cycle(1'b0, 8'h08, 32'h0);
    `CHK(rd_val, 32'h03)
    wb_cycle(1'b1, 8'h08, 32'h00);
    wb_cycle(1'b1, 8'h00, 32'h00);
    tick();
    wb_cycle(1'b0, 8'h00, 32'h0);
    `CHK(rd_val, 32'h00)
    wb_cycle(1'b1, 8'h08, 32'h01);
  endtask : t_free

  task t_clear;
    wb_cycle(1'b1, 8'h00, 32'h42);
    wb_cycle(1'b1, 8'h08, 32'h05);
    wb_cycle(1'b0, 8'h00, 32'h0);
    `CHK(rd_val, 32'h00)
    wb_cycle(1'b0, 8'h04, 32'h0);
    `CHK(rd_val, 32'h00)
    wb_cycle(1'b0, 8'h08, 32'h0);
    `CHK(rd_val, 32'h01)
    wb_cycle(1'b0, 8'h0C, 32'h0);
    `CHK(rd_val, 32'h00)
  endtask : t_clear

  task t_busy;
    @(posedge core_clk_i);
    hour_busy_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    `CHK(update_in_progress_o, 1'b1)
    wb_cycle(1'b0, 8'h00, 32'h0);
    `CHK(rd_val, 32'h80)
    wb_cycle(1'b0, 8'h0C, 32'h0);
    `CHK(rd_val, 32'h01)
    hour_busy_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    `CHK(update_in_progress_o, 1'b0)
    wb_cycle(1'b0, 8'h04, 32'h0);
    `CHK(rd_val[7], 1'b0)
    `CHK(rd_val, 32'h00)
  endtask : t_busy

  task t_rst_mid;
    wb_cycle(1'b1, 8'h04, 32'h23);
    wb_cycle(1'b1, 8'h08, 32'h02);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    wb_cycle(1'b0, 8'h04, 32'h0);
    `CHK(rd_val, 32'h00)
    wb_cycle(1'b0, 8'h08, 32'h0);
    `CHK(rd_val, 32'h01)
    `CHK(update_in_progress_o, 1'b0)
    `CHK(hour_carry_o, 1'b0)
  endtask : t_rst_mid

  task complete_run;
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  initial
  begin
    repeat (5000) @(posedge core_clk_i);
    err_count++;
    complete_run();
  end

  initial
  begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, sec_tick_i, hour_busy_i} = 5'h00;
    wb_sel_i = 4'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_bcd();
    t_free();
    t_clear();
    t_busy();
    t_rst_mid();
    complete_run();
  end
endmodule : testbench
